/* File: hw/status_led_alert_logic.sv */
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "led_consts.svh"

module status_led_alert_logic
  import led_pkg::*;
#(
  parameter int unsigned DW           = 16,
  parameter int unsigned BLINK_CYCLES = `CLK_HZ / 1000 * `BLINK_HALF_MS,
  parameter int unsigned SEC_CYCLES   = `CLK_HZ / 1000 * `SEC_MS
)(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic [DW-1:0] temp_value,
  input  wire logic [DW-1:0] hum_value,
  input  wire logic [DW-1:0] co2_value,
  input  wire logic [DW-1:0] light_value,
  input  wire logic          frame_ok,
  input  wire logic          sensor_link_lost,
  output logic               led_green,
  output logic               led_yellow,
  output logic               led_red,
  output logic               bus_termination_switch,
  output logic               auto_baseline_correction,
  output logic [1:0]         light_state
);

  function automatic logic outside_band(input logic [DW-1:0] v, input logic [31:0] band);
    outside_band = (v < band[DW-1:0]) || (v > band[`HI_FIELD_LSB+DW-1:`HI_FIELD_LSB]);
  endfunction

  function automatic logic at_range_end(input logic [DW-1:0] v, input logic [31:0] band);
    at_range_end = (v <= band[DW-1:0]) || (v >= band[`HI_FIELD_LSB+DW-1:`HI_FIELD_LSB]);
  endfunction

  logic [3:0]  ctrl_q;
  logic [15:0] bus_tmo_q;
  logic [31:0] temp_alert_q;
  logic [31:0] hum_alert_q;
  logic [31:0] temp_range_q;
  logic [31:0] hum_range_q;
  logic [31:0] co2_alert_q;
  logic [31:0] light_lvl_q;
  logic [7:0]  addr_q;
  logic        wr_q;

  // Bus slave: zero wait states, always OKAY
  wire         addr_phase = hsel && htrans[1] && hready;
  wire         wr_ctrl    = wr_q && (addr_q == `OFS_CTRL);
  wire         wr_tmo     = wr_q && (addr_q == `OFS_BUS_TMO);
  wire         wr_ta      = wr_q && (addr_q == `OFS_TEMP_ALERT);
  wire         wr_ha      = wr_q && (addr_q == `OFS_HUM_ALERT);
  wire         wr_tr      = wr_q && (addr_q == `OFS_TEMP_RANGE);
  wire         wr_hr      = wr_q && (addr_q == `OFS_HUM_RANGE);
  wire         wr_co2     = wr_q && (addr_q == `OFS_CO2_ALERT);
  wire         wr_light   = wr_q && (addr_q == `OFS_LIGHT_LVL);

  logic [`ST_WIDTH-1:0] status_w;
  logic [31:0]          rd_mux;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_q    <= 8'h00;
      wr_q      <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      addr_q    <= haddr[7:0];
      wr_q      <= addr_phase && hwrite && (haddr[31:8] == 24'h00_0000);
      hrdata    <= (addr_phase && !hwrite) ? rd_mux : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is captured in the address phase so it stands in the data phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      unique case (haddr[7:0])
        `OFS_CTRL:       rd_mux = {28'h000_0000, ctrl_q};
        `OFS_BUS_TMO:    rd_mux = {16'h0000, bus_tmo_q};
        `OFS_TEMP_ALERT: rd_mux = temp_alert_q;
        `OFS_HUM_ALERT:  rd_mux = hum_alert_q;
        `OFS_TEMP_RANGE: rd_mux = temp_range_q;
        `OFS_HUM_RANGE:  rd_mux = hum_range_q;
        `OFS_CO2_ALERT:  rd_mux = co2_alert_q;
        `OFS_LIGHT_LVL:  rd_mux = light_lvl_q;
        `OFS_STATUS:     rd_mux = {26'h000_0000, status_w};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q       <= `CTRL_RST;
      bus_tmo_q    <= `BUS_TMO_RST;
      temp_alert_q <= `BAND_RST;
      hum_alert_q  <= `BAND_RST;
      temp_range_q <= `BAND_RST;
      hum_range_q  <= `BAND_RST;
      co2_alert_q  <= `CO2_ALERT_RST;
      light_lvl_q  <= `BAND_RST;
    end
    else
    begin
      if (wr_ctrl)  ctrl_q       <= hwdata[3:0];
      if (wr_tmo)   bus_tmo_q    <= hwdata[15:0];
      if (wr_ta)    temp_alert_q <= hwdata;
      if (wr_ha)    hum_alert_q  <= hwdata;
      if (wr_tr)    temp_range_q <= hwdata;
      if (wr_hr)    hum_range_q  <= hwdata;
      if (wr_co2)   co2_alert_q  <= hwdata;
      if (wr_light) light_lvl_q  <= hwdata;
    end
  end

  // Shared blink phase and one-second tick for the bus timeout
  logic [31:0] blink_cnt_q;
  logic [31:0] sec_cnt_q;
  logic [15:0] elapsed_q;
  logic        blink_q;
  wire         blink_tick = (blink_cnt_q == BLINK_CYCLES - 1);
  wire         sec_tick   = (sec_cnt_q == SEC_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= 1'b0;
    end
    else
    begin
      blink_cnt_q <= blink_tick ? 32'h0000_0000 : blink_cnt_q + 32'h0000_0001;
      if (blink_tick)
        blink_q <= !blink_q;
    end
  end

  // A frame restarts the wait; it wins over a second tick in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sec_cnt_q <= 32'h0000_0000;
      elapsed_q <= 16'h0000;
    end
    else if (frame_ok)
    begin
      sec_cnt_q <= 32'h0000_0000;
      elapsed_q <= 16'h0000;
    end
    else
    begin
      sec_cnt_q <= sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
      if (sec_tick && (elapsed_q != 16'hFFFF))
        elapsed_q <= elapsed_q + 16'h0001;
    end
  end

  wire tmo_active = (bus_tmo_q != 16'h0000) && (elapsed_q >= bus_tmo_q) && !frame_ok;

  // Measurement classification
  wire boot       = ctrl_q[`CTRL_BOOT_BIT];
  wire download   = ctrl_q[`CTRL_DL_BIT];
  wire red_meas   = at_range_end(temp_value, temp_range_q)
                 || at_range_end(hum_value, hum_range_q)
                 || (co2_value >= co2_alert_q[`HI_FIELD_LSB+DW-1:`HI_FIELD_LSB]);
  wire yel_alert  = outside_band(temp_value, temp_alert_q)
                 || outside_band(hum_value, hum_alert_q)
                 || (co2_value >= co2_alert_q[DW-1:0]);
  wire red_any    = red_meas || sensor_link_lost;

  led_mode_e mode;
  assign mode = boot      ? MODE_BOOT      :
                red_any   ? MODE_RED       :
                yel_alert ? MODE_YEL_ALERT :
                tmo_active ? MODE_YEL_BLINK : MODE_GREEN;

  logic green_d;
  logic yellow_d;
  logic red_d;

  always_comb
  begin
    green_d  = 1'b0;
    yellow_d = 1'b0;
    red_d    = 1'b0;
    unique case (mode)
      MODE_BOOT:
      begin
        green_d  = blink_q;
        yellow_d = !blink_q;
        red_d    = download && blink_q;
      end
      MODE_RED:       red_d    = red_meas ? 1'b1 : blink_q;
      MODE_YEL_ALERT: yellow_d = 1'b1;
      MODE_YEL_BLINK: yellow_d = blink_q;
      MODE_GREEN:     green_d  = 1'b1;
    endcase
  end

  wire light_stby = light_value < light_lvl_q[DW-1:0];
  wire light_act  = light_value > light_lvl_q[`HI_FIELD_LSB+DW-1:`HI_FIELD_LSB];
  light_state_e light_d;
  assign light_d = light_stby ? LIGHT_STANDBY : light_act ? LIGHT_ACTIVE : LIGHT_LOW;

  assign status_w = {tmo_active, led_red, led_yellow, led_green, light_state};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_green                <= 1'b0;
      led_yellow               <= 1'b0;
      led_red                  <= 1'b0;
      bus_termination_switch   <= 1'b0;
      auto_baseline_correction <= 1'b1;
      light_state              <= 2'h0;
    end
    else
    begin
      led_green                <= green_d;
      led_yellow               <= yellow_d;
      led_red                  <= red_d;
      bus_termination_switch   <= ctrl_q[`CTRL_TERM_BIT];
      auto_baseline_correction <= ctrl_q[`CTRL_ABC_BIT];
      light_state              <= light_d;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_GREEN_ONLY: assert property (
    mode == MODE_GREEN |=> led_green && !led_yellow && !led_red)
    else $error("green mode did not show green alone");
  AST_YEL_STEADY: assert property (
    !boot && !red_any && yel_alert |=> led_yellow && !led_green)
    else $error("alert did not light yellow steadily");
  AST_YEL_BLINK: assert property (
    mode == MODE_YEL_BLINK |=> led_yellow == $past(blink_q))
    else $error("timeout yellow does not follow blink phase");
  AST_TMO_STOP: assert property (
    frame_ok |-> !tmo_active ##1 (elapsed_q == 16'h0000))
    else $error("frame did not end the timeout");
  AST_ALERT_WINS: assert property (
    tmo_active && yel_alert && !boot && !red_any |=> led_yellow [*1])
    else $error("timeout blink overrode alert yellow");
  AST_RED_STEADY: assert property (
    !boot && red_meas |=> led_red && !led_green && !led_yellow)
    else $error("range limit did not light red");
  AST_RED_BLINK: assert property (
    !boot && !red_meas && sensor_link_lost |=> led_red == $past(blink_q))
    else $error("lost sensor does not blink red");
  AST_BOOT_ALT: assert property (
    boot |=> (led_green != led_yellow) && (led_green == $past(blink_q)))
    else $error("boot pattern not alternating");
  AST_BOOT_DL: assert property (
    boot && !download |=> !led_red)
    else $error("red lit in boot without download");
  AST_LIGHT_STBY: assert property (
    light_stby |=> light_state == LIGHT_STANDBY)
    else $error("light standby not reported");
  AST_TERM: assert property (
    wr_ctrl |-> ##2 bus_termination_switch == $past(hwdata[`CTRL_TERM_BIT], 2))
    else $error("termination did not follow write");
  AST_LIT: assert property (
    mode inside {MODE_GREEN, MODE_YEL_ALERT} |=> led_green || led_yellow)
    else $error("no LED lit for measured status");
  AST_TICK: assert property (
    blink_tick |=> blink_q != $past(blink_q))
    else $error("blink phase did not toggle on tick");

endmodule // status_led_alert_logic

`default_nettype wire

/* File: pkg/led_consts.svh */
`ifndef LED_CONSTS_SVH
`define LED_CONSTS_SVH

`define CLK_HZ          40000000
`define BLINK_HALF_MS   250
`define SEC_MS          1000

`define OFS_CTRL        8'h00
`define OFS_BUS_TMO     8'h04
`define OFS_TEMP_ALERT  8'h08
`define OFS_HUM_ALERT   8'h0C
`define OFS_TEMP_RANGE  8'h10
`define OFS_HUM_RANGE   8'h14
`define OFS_CO2_ALERT   8'h18
`define OFS_LIGHT_LVL   8'h1C
`define OFS_STATUS      8'h20

`define CTRL_TERM_BIT   0
`define CTRL_ABC_BIT    1
`define CTRL_BOOT_BIT   2
`define CTRL_DL_BIT     3

`define CTRL_RST        4'h2
`define BUS_TMO_RST     16'h0000
`define BAND_RST        32'hFFFF_0000
`define CO2_ALERT_RST   32'hFFFF_FFFF

`define ST_LIGHT_LSB    0
`define ST_LIGHT_MSB    1
`define ST_GREEN_BIT    2
`define ST_YELLOW_BIT   3
`define ST_RED_BIT      4
`define ST_TMO_BIT      5
`define ST_WIDTH        6

`define HI_FIELD_LSB    16

`endif

/* File: pkg/led_pkg.sv */
`default_nettype none

package led_pkg;

  typedef enum logic [1:0] {
    LIGHT_STANDBY,
    LIGHT_LOW,
    LIGHT_ACTIVE
  } light_state_e;

  typedef enum logic [2:0] {
    MODE_BOOT,
    MODE_RED,
    MODE_YEL_ALERT,
    MODE_YEL_BLINK,
    MODE_GREEN
  } led_mode_e;

endpackage

`default_nettype wire

/* File: tb/field_master.sv */
`timescale 1ns/1ps
`default_nettype none

module field_master
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic talk,
  output logic      frame_ok
);
  logic [1:0] gap_q;

  // A frame every fourth cycle, far inside any whole-second timeout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_q    <= 2'h0;
      frame_ok <= 1'b0;
    end
    else
    begin
      gap_q    <= gap_q + 2'h1;
      frame_ok <= talk && (gap_q == 2'h3);
    end
  end
  // This node is one of the two bus ends, so the bench turns its termination on
endmodule // field_master

`default_nettype wire

/* File: tb/test_status_led_alert_logic.sv */
`timescale 1ns/1ps
`default_nettype none
`include "led_consts.svh"

module test_status_led_alert_logic;
  import led_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        talk = 1'b1, lost = 1'b0, rd_ph = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0, lst;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] temp = 16'h0800, hum = 16'h0800, co2 = 16'h0000, light = 16'h0050;
  logic        hreadyout, hresp, frame_ok, g, y, r, term, abc;
  logic [31:0] exp_q [$];
  int          failures = 0, comparisons = 0, gn, yn, rn, dn;
  logic [15:0] tt [6] = '{16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0080, 16'hFFFF};
  logic [15:0] cc [6] = '{16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000, 16'h0000, 16'h0000};
  logic [2:0]  ee [6] = '{3'h4, 3'h2, 3'h2, 3'h1, 3'h2, 3'h1};

  status_led_alert_logic #(.BLINK_CYCLES(8), .SEC_CYCLES(16)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .temp_value(temp), .hum_value(hum),
    .co2_value(co2), .light_value(light), .frame_ok(frame_ok), .sensor_link_lost(lost),
    .led_green(g), .led_yellow(y), .led_red(r), .bus_termination_switch(term),
    .auto_baseline_correction(abc), .light_state(lst));

  field_master peer_u (.hclk(hclk), .hresetn(hresetn), .talk(talk), .frame_ok(frame_ok));

  initial
  begin
    forever #12.5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph  <= !w;
    if (!w)
      exp_q.push_back(e);
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd_ph <= 1'b0;
  endtask

  // Counts lit cycles over five blink half periods
  task automatic watch();
    gn = 0;
    yn = 0;
    rn = 0;
    dn = 0;
    // One edge first so a setting written just before has reached the LEDs
    @(posedge hclk);
    repeat (40)
    begin
      @(negedge hclk);
      gn += int'(g);
      yn += int'(y);
      rn += int'(r);
      dn += int'(g != y);
    end
    @(posedge hclk);
  endtask

  function automatic logic [31:0] blinks(input int n);
    return 32'(n > 0 && n < 40);
  endfunction

  always @(posedge hclk)
  begin
    if (rd_ph && hreadyout)
    begin
      chk(hrdata, exp_q.pop_front());
      chk(32'(hresp), 32'h0000_0000);
    end
  end

  initial
  begin
    #500000;
    failures++;
    summarize();
  end

  initial
  begin
    void'($urandom(32'h4CE252B6));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `OFS_CTRL, 32'h0, 32'h2);
    chk(32'({g, y, r, abc, term}), 32'h12);
    xfer(1'b1, `OFS_CTRL, 32'h1, 32'h0);
    xfer(1'b0, 8'h40, 32'h0, 32'h0);
    xfer(1'b1, `OFS_STATUS, 32'hFFFF_FFFF, 32'h0);
    chk(32'({term, abc}), 32'h2);
    $display("test reset and control done");
    xfer(1'b1, `OFS_CO2_ALERT, 32'h2000_1000, 32'h0);
    xfer(1'b1, `OFS_TEMP_ALERT, 32'hF000_0100, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge hclk);
      temp <= tt[i];
      co2  <= cc[i];
      hum  <= 16'h0100 + 16'($urandom % 32'hE00);
      repeat (3) @(posedge hclk);
      chk(32'({g, y, r}), 32'(ee[i]));
      xfer(1'b0, `OFS_STATUS, 32'h0, {27'h0, ee[i][0], ee[i][1], ee[i][2], 2'h1});
    end
    $display("test alert levels done");
    xfer(1'b1, `OFS_LIGHT_LVL, 32'h0200_0100, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      light <= (i == 0) ? 16'h00FF : (i == 1) ? 16'h0100 : (i == 2) ? 16'h0200 : 16'h0201;
      repeat (3) @(posedge hclk);
      chk(32'(lst), (i == 0) ? 32'h0 : (i == 3) ? 32'h2 : 32'h1);
    end
    $display("test light state done");
    temp <= 16'h0800;
    co2  <= 16'h0000;
    talk <= 1'b1;
    xfer(1'b1, `OFS_BUS_TMO, 32'h1, 32'h0);
    watch();
    chk(32'(yn), 32'h0);
    talk <= 1'b0;
    repeat (20) @(posedge hclk);
    watch();
    chk(blinks(yn), 32'h1);
    talk <= 1'b1;
    repeat (6) @(posedge hclk);
    watch();
    chk(32'({16'(yn), 16'(gn)}), 32'h0000_0028);
    talk <= 1'b0;
    co2  <= 16'h1000;
    repeat (20) @(posedge hclk);
    watch();
    chk(32'(yn), 32'(40));
    co2 <= 16'h0000;
    xfer(1'b1, `OFS_BUS_TMO, 32'h0, 32'h0);
    watch();
    chk(32'(yn), 32'h0);
    $display("test bus timeout done");
    lost <= 1'b1;
    repeat (3) @(posedge hclk);
    watch();
    chk(blinks(rn), 32'h1);
    lost <= 1'b0;
    co2  <= 16'h1000;
    xfer(1'b1, `OFS_CTRL, 32'h4, 32'h0);
    watch();
    chk(32'({blinks(gn), 8'(dn), 8'(rn)}), 32'h0001_2800);
    xfer(1'b1, `OFS_CTRL, 32'hC, 32'h0);
    watch();
    chk(32'({blinks(rn), 8'(dn)}), 32'h0000_0128);
    $display("test bootloader done");
    summarize();
  end
endmodule // test_status_led_alert_logic

`default_nettype wire
